// ==== verif/cfg_host_model.sv ====
// Host-side Avalon master model issuing configuration accesses
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module cfg_host_model (
    input  wire logic        clock,
    input  wire logic [31:0] readdata,
    input  wire logic        waitrequest,
    output logic      [1:0]  address,
    output logic             read,
    output logic             write,
    output logic      [31:0] writedata,
    output logic      [3:0]  byteenable
);
    initial begin
        address    = 2'h0;
        read       = 1'b0;
        write      = 1'b0;
        writedata  = 32'h0000_0000;
        byteenable = 4'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Waits as long as the slave needs; only the bench watchdog ends a hang
    task automatic access(input logic is_wr, input logic [1:0] adr, input logic [31:0] wd,
                          input logic [3:0] be, output logic [31:0] rd, output logic late);
        int n;
        n = 0;
        @(posedge clock);
        address    <= adr;
        writedata  <= wd;
        byteenable <= be;
        read       <= !is_wr;
        write      <= is_wr;
        @(posedge clock);
        while (waitrequest !== 1'b0) begin
            n++;
            @(posedge clock);
        end
        rd   = readdata;
        // Slave promises exactly one wait cycle per access
        late = (n != 1);
        read      <= 1'b0;
        write     <= 1'b0;
        // Released data and address lines show a changed value, not the last one
        writedata <= ~wd;
        address   <= ~adr;
    endtask : access
endmodule : cfg_host_model

// ==== verif/test_pci_cacheline_latency_config.sv ====
// Self-checking bench for the cache line / latency configuration registers
`timescale 1ns/10ps
module test_pci_cacheline_latency_config;
    import cfg_pkg::*;
    localparam logic [7:0] HDR = 8'h80;
    localparam logic [7:0] CORNER [15] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h07, 8'h08, 8'h09,
                                            8'h0F, 8'h10, 8'h11, 8'h1F, 8'h20, 8'h21, 8'hFF};
    localparam logic [7:0] SIZES [5]   = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h20};
    localparam logic [7:0] LIMS [3]    = '{8'h00, 8'h01, 8'h05};
    logic        clock           = 1'b0;
    logic        rst_n           = 1'b0;
    logic        frame_strobe    = 1'b0;
    logic        bus_grant_input = 1'b1;
    logic        multi_phase     = 1'b0;
    logic        xfer_is_write   = 1'b0;
    logic [7:0]  xfer_words      = 8'h00;
    logic [1:0]  address;
    logic        read, write, waitrequest, burst_stop, late;
    logic [31:0] writedata, readdata, rd;
    logic [3:0]  byteenable, mem_cmd;
    logic [7:0]  master_latency_limit, cacheline_word_count, prefetch_words;
    int          miscompares = 0;
    int          total_checks = 0;
    int          seed;

    always #25 clock = ~clock;

    cacheline_latency_regs #(.HEADER_LAYOUT(HDR)) uut (
        .clock(clock), .rst_n(rst_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .frame_strobe(frame_strobe), .bus_grant_input(bus_grant_input), .multi_phase(multi_phase),
        .xfer_is_write(xfer_is_write), .xfer_words(xfer_words), .master_latency_limit(master_latency_limit),
        .cacheline_word_count(cacheline_word_count), .mem_cmd(mem_cmd), .prefetch_words(prefetch_words),
        .burst_stop(burst_stop));

    cfg_host_model host (
        .clock(clock), .readdata(readdata), .waitrequest(waitrequest), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable));

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : test_done

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [1:0] adr, input logic [31:0] wd, input logic [3:0] be);
        host.access(1'b1, adr, wd, be, rd, late);
        check(late, 1'b0);
    endtask : wr

    task automatic rdv(input logic [1:0] adr);
        host.access(1'b0, adr, 32'h0000_0000, 4'hF, rd, late);
        check(late, 1'b0);
    endtask : rdv

    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : settle

    function automatic logic [7:0] cls_exp(input logic [7:0] v);
        return (v inside {8'h00, 8'h04, 8'h08, 8'h10, 8'h20}) ? v : 8'h00;
    endfunction : cls_exp

    function automatic logic [3:0] cmd_exp(input logic wr_op, input logic mwi, input logic [7:0] cls,
                                           input logic [7:0] words);
        if (wr_op) return (mwi && cls != 8'h00 && words >= cls) ? CMD_WRITE_INV : CMD_MEM_WRITE;
        if (cls == 8'h00 || words <= 8'h01) return CMD_MEM_READ;
        return (words <= cls) ? CMD_READ_LINE : CMD_READ_MULTI;
    endfunction : cmd_exp

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #(50 * 20000);
        miscompares++;
        test_done;
    end

    initial begin
        logic [7:0] v, lat, w;
        int         n;
        seed = 49;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        settle(1);
        check(mem_cmd, CMD_MEM_READ);
        check(prefetch_words, PREFETCH_MIN);
        rdv(ADDR_CFG_WORD);
        check(rd, {BIST_VALUE, HDR, LAT_RESET, CLS_RESET});
        wr(2'h3, 32'hFFFF_FFFF, 4'hF);
        rdv(2'h3);
        check(rd, READ_ZERO);
        for (int i = 0; i < 35; i++) begin
            v   = (i < 15) ? CORNER[i] : 8'($random(seed));
            lat = 8'($random(seed));
            wr(ADDR_CFG_WORD, {16'($random(seed)), lat, v}, 4'hF);
            rdv(ADDR_CFG_WORD);
            check(rd, {BIST_VALUE, HDR, lat, cls_exp(v)});
            check(cacheline_word_count, cls_exp(v));
            check(master_latency_limit, lat);
            check(prefetch_words, (cls_exp(v) == 8'h00) ? PREFETCH_MIN : cls_exp(v));
        end
        // Latency lane alone must leave the size field untouched
        wr(ADDR_CFG_WORD, 32'h0000_3300, 4'h2);
        rdv(ADDR_CFG_WORD);
        check(rd, {BIST_VALUE, HDR, 8'h33, cls_exp(v)});
        for (int m = 0; m < 2; m++) begin
            for (int s = 0; s < 5; s++) begin
                for (int k = 0; k < 6; k++) begin
                    wr(ADDR_CTRL, {30'h0, m[0], 1'b0}, 4'h1);
                    wr(ADDR_CFG_WORD, {24'h0, SIZES[s]}, 4'h1);
                    w = (k < 2) ? SIZES[s] : (k < 4) ? SIZES[s] + 8'h01 : 8'($random(seed) & 8'h3F);
                    @(posedge clock);
                    xfer_words    <= w;
                    xfer_is_write <= k[0];
                    settle(3);
                    check(mem_cmd, cmd_exp(k[0], m[0], SIZES[s], w));
                end
            end
        end
        for (int t = 0; t < 6; t++) begin
            lat = (t < 3) ? LIMS[t] : 8'($random(seed) & 8'h1F);
            wr(ADDR_CFG_WORD, {16'h0, lat, 8'h00}, 4'h2);
            @(posedge clock);
            frame_strobe    <= 1'b1;
            multi_phase     <= (t != 4);
            bus_grant_input <= (t == 5);
            n = 0;
            do begin
                @(posedge clock);
                #1;
                n++;
            end while (burst_stop !== 1'b1 && n < int'(lat) + 40);
            if (t < 4) check(n >= int'(lat) + 1 && n <= int'(lat) + 2, 1'b1);
            else check(burst_stop, 1'b0);
            rdv(ADDR_STATUS);
            check(rd & 32'h0000_F3FF,
                  {16'h0000, cmd_exp(1'b1, 1'b1, SIZES[4], w), 2'b00, t < 4, 1'b1, 8'h00});
            @(posedge clock);
            frame_strobe    <= 1'b0;
            multi_phase     <= 1'b0;
            bus_grant_input <= 1'b1;
            settle(2);
        end
        // Soft reset keeps the latency byte, hardware reset clears it
        wr(ADDR_CFG_WORD, 32'h0000_5A08, 4'h3);
        wr(ADDR_CTRL, 32'h0000_0001, 4'h1);
        rdv(ADDR_CFG_WORD);
        check(rd, {BIST_VALUE, HDR, 8'h5A, CLS_RESET});
        rdv(ADDR_CTRL);
        check(rd, READ_ZERO);
        @(posedge clock);
        rst_n <= 1'b0;
        settle(2);
        check(master_latency_limit, LAT_RESET);
        @(posedge clock);
        rst_n <= 1'b1;
        settle(1);
        rdv(ADDR_CFG_WORD);
        check(rd, {BIST_VALUE, HDR, LAT_RESET, CLS_RESET});
        test_done;
    end
endmodule : test_pci_cacheline_latency_config

// ==== verilog/cacheline_latency_regs.sv ====
// Cache line size / latency timer configuration registers with Avalon slave
//
// The implementer's own choices: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
module cacheline_latency_regs
    import cfg_pkg::*;
#(
    parameter logic [7:0] HEADER_LAYOUT = HDR_LAYOUT_DEFAULT
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [1:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic        frame_strobe,
    input  wire logic        bus_grant_input,
    input  wire logic        multi_phase,
    input  wire logic        xfer_is_write,
    input  wire logic [7:0]  xfer_words,
    output logic      [7:0]  master_latency_limit,
    output logic      [7:0]  cacheline_word_count,
    output logic      [3:0]  mem_cmd,
    output logic      [7:0]  prefetch_words,
    output logic             burst_stop
);

    ////////////////////////////////////////////////////////////////////////////
    // Cache line value check
    function automatic logic cls_supported(input logic [7:0] v);
        logic ok;
        ok = 1'b0;
        unique case (v)
            CLS_DISABLED, CLS_16_BYTES, CLS_32_BYTES: ok = 1'b1;
            CLS_64_BYTES, CLS_128_BYTES:              ok = 1'b1;
            default:                                  ok = 1'b0;
        endcase
        return ok;
    endfunction : cls_supported

    ////////////////////////////////////////////////////////////////////////////
    // Avalon slave handshake: one wait cycle per access
    logic        wait_q;
    logic        wait_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        req;
    logic        commit;
    logic [31:0] rd_mux;

    logic [7:0]  lat_q;
    logic [7:0]  lat_d;
    logic [7:0]  cls_q;
    logic [7:0]  cls_d;
    logic        mwi_en_q;
    logic        mwi_en_d;
    logic [3:0]  cmd_q;
    logic [3:0]  cmd_d;
    logic [7:0]  pref_q;
    logic [7:0]  pref_d;
    logic        frame_q;
    logic        frame_d;

    logic [7:0]  lc_count;
    logic        lc_expired;
    logic        lc_stop;
    logic        frame_start;
    logic        soft_reset;

    assign req    = read || write;
    assign commit = req && !wait_q;

    always_comb begin
        rd_mux = READ_ZERO;
        unique case (address)
            ADDR_CFG_WORD: begin
                rd_mux[BIST_LSB +: 8] = BIST_VALUE;
                rd_mux[HDR_LSB +: 8]  = HEADER_LAYOUT;
                rd_mux[LAT_LSB +: 8]  = lat_q;
                rd_mux[CLS_LSB +: 8]  = cls_q;
            end
            ADDR_CTRL: begin
                rd_mux[CTRL_MWI_EN_BIT] = mwi_en_q;
            end
            ADDR_STATUS: begin
                rd_mux[STAT_COUNT_LSB +: 8] = lc_count;
                rd_mux[STAT_EXPIRED_BIT]    = lc_expired;
                rd_mux[STAT_STOP_BIT]       = lc_stop;
                rd_mux[STAT_CMD_LSB +: 4]   = cmd_q;
            end
            // Unmapped word reads as zero, writes dropped
            default: rd_mux = READ_ZERO;
        endcase
    end

    always_comb begin
        wait_d  = 1'b1;
        rdata_d = rdata_q;
        if (req && wait_q) begin
            wait_d  = 1'b0;
            rdata_d = rd_mux;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wait_q  <= 1'b1;
            rdata_q <= READ_ZERO;
        end else begin
            wait_q  <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register writes, taken on the edge that completes the access
    assign soft_reset = commit && write && address == ADDR_CTRL && byteenable[0]
                        && writedata[CTRL_SOFT_RESET_BIT];

    always_comb begin
        lat_d    = lat_q;
        cls_d    = cls_q;
        mwi_en_d = mwi_en_q;
        if (commit && write && address == ADDR_CFG_WORD) begin
            // Bytes 3 and 2 are read-only; byte lanes ignored there
            if (byteenable[1]) begin
                lat_d = writedata[LAT_LSB +: 8];
            end
            if (byteenable[0]) begin
                // Value counts 32-bit words
                cls_d = cls_supported(writedata[CLS_LSB +: 8]) ? writedata[CLS_LSB +: 8] : CLS_DISABLED;
            end
        end
        if (commit && write && address == ADDR_CTRL && byteenable[0]) begin
            mwi_en_d = writedata[CTRL_MWI_EN_BIT];
        end
        if (soft_reset) begin
            // Latency limit deliberately survives a soft reset
            cls_d    = CLS_RESET;
            mwi_en_d = MWI_EN_RESET;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lat_q    <= LAT_RESET;
            cls_q    <= CLS_RESET;
            mwi_en_q <= MWI_EN_RESET;
        end else begin
            lat_q    <= lat_d;
            cls_q    <= cls_d;
            mwi_en_q <= mwi_en_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Master command choice and slave prefetch sizing
    always_comb begin
        if (xfer_is_write) begin
            // Invalidate form only for whole lines when enabled
            if (mwi_en_q && cls_q != CLS_DISABLED && xfer_words >= cls_q) begin
                cmd_d = CMD_WRITE_INV;
            end else begin
                cmd_d = CMD_MEM_WRITE;
            end
        end else if (cls_q == CLS_DISABLED || xfer_words <= 8'h01) begin
            cmd_d = CMD_MEM_READ;
        end else if (xfer_words <= cls_q) begin
            cmd_d = CMD_READ_LINE;
        end else begin
            cmd_d = CMD_READ_MULTI;
        end
        // Disabled line size leaves prefetch at a single word
        pref_d = (cls_q == CLS_DISABLED) ? PREFETCH_MIN : cls_q;
        frame_d = frame_strobe;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cmd_q   <= CMD_MEM_READ;
            pref_q  <= PREFETCH_MIN;
            frame_q <= 1'b0;
        end else begin
            cmd_q   <= cmd_d;
            pref_q  <= pref_d;
            frame_q <= frame_d;
        end
    end

    assign frame_start = frame_strobe && !frame_q;

    ////////////////////////////////////////////////////////////////////////////
    // Latency enforcement
    latency_counter #(
        .WIDTH (8)
    ) u_latency (
        .clock           (clock),
        .rst_n           (rst_n),
        .frame_start     (frame_start),
        .frame_active    (frame_strobe),
        .bus_grant_input (bus_grant_input),
        .multi_phase     (multi_phase),
        .limit           (lat_q),
        .count_q         (lc_count),
        .expired_q       (lc_expired),
        .stop_q          (lc_stop)
    );

    assign readdata             = rdata_q;
    assign waitrequest          = wait_q;
    assign master_latency_limit = lat_q;
    assign cacheline_word_count = cls_q;
    assign mem_cmd              = cmd_q;
    assign prefetch_words       = pref_q;
    assign burst_stop           = lc_stop;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_bist_zero;
        @(posedge clock) disable iff (!rst_n)
        (read && !wait_q && address == ADDR_CFG_WORD) |-> readdata[BIST_LSB +: 8] == BIST_VALUE;
    endproperty
    a_bist_zero: assert property (p_bist_zero) else $error("Self-test byte not zero");

    property p_header_byte;
        @(posedge clock) disable iff (!rst_n)
        (read && !wait_q && address == ADDR_CFG_WORD) |-> readdata[HDR_LSB +: 8] == HEADER_LAYOUT;
    endproperty
    a_header_byte: assert property (p_header_byte) else $error("Header byte wrong");

    property p_stop_needs_no_grant;
        @(posedge clock) disable iff (!rst_n)
        burst_stop |-> !$past(bus_grant_input) && $past(multi_phase);
    endproperty
    a_stop_needs_no_grant: assert property (p_stop_needs_no_grant) else $error("Burst stop with grant");

    property p_soft_reset_keeps_lat;
        @(posedge clock) disable iff (!rst_n)
        soft_reset |=> lat_q == $past(lat_q) && cls_q == CLS_RESET;
    endproperty
    a_soft_reset_keeps_lat: assert property (p_soft_reset_keeps_lat) else $error("Soft reset hit latency");

    property p_unsupported_zero;
        @(posedge clock) disable iff (!rst_n)
        (commit && write && address == ADDR_CFG_WORD && byteenable[0]
         && !cls_supported(writedata[7:0])) |=> cls_q == CLS_DISABLED;
    endproperty
    a_unsupported_zero: assert property (p_unsupported_zero) else $error("Unsupported size stored");

    property p_small_sizes_kept;
        @(posedge clock) disable iff (!rst_n)
        (commit && write && address == ADDR_CFG_WORD && byteenable[0] && !soft_reset
         && (writedata[7:0] == CLS_16_BYTES || writedata[7:0] == CLS_32_BYTES))
        |=> cls_q == $past(writedata[7:0]);
    endproperty
    a_small_sizes_kept: assert property (p_small_sizes_kept) else $error("16/32 byte size lost");

    property p_large_sizes_kept;
        @(posedge clock) disable iff (!rst_n)
        (commit && write && address == ADDR_CFG_WORD && byteenable[0]
         && (writedata[7:0] == CLS_64_BYTES || writedata[7:0] == CLS_128_BYTES))
        |=> cls_q == $past(writedata[7:0]);
    endproperty
    a_large_sizes_kept: assert property (p_large_sizes_kept) else $error("64/128 byte size lost");

    property p_counter_load;
        @(posedge clock) disable iff (!rst_n)
        frame_start |=> lc_count == $past(lat_q) ##1 (!$past(frame_strobe) || lc_count == '0
                        || lc_count == $past(lc_count) - 8'h01);
    endproperty
    a_counter_load: assert property (p_counter_load) else $error("Latency counter not loaded");

    property p_wrinv_needs_line;
        @(posedge clock) disable iff (!rst_n)
        mem_cmd == CMD_WRITE_INV |-> $past(cls_q) != CLS_DISABLED && $past(mwi_en_q);
    endproperty
    a_wrinv_needs_line: assert property (p_wrinv_needs_line) else $error("Invalidate without line");

    property p_prefetch_follows;
        @(posedge clock) disable iff (!rst_n)
        ($stable(cls_q) && cls_q != CLS_DISABLED) |=> prefetch_words == $past(cls_q);
    endproperty
    a_prefetch_follows: assert property (p_prefetch_follows) else $error("Prefetch size mismatch");

    property p_one_wait;
        @(posedge clock) disable iff (!rst_n)
        (req && wait_q) |=> !waitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("Slave did not answer");

    property p_cls_legal;
        @(posedge clock) disable iff (!rst_n)
        cls_supported(cacheline_word_count);
    endproperty
    a_cls_legal: assert property (p_cls_legal) else $error("Unsupported size held");

    c_write_line: cover property (@(posedge clock) disable iff (!rst_n) mem_cmd == CMD_WRITE_INV);
    c_read_multi: cover property (@(posedge clock) disable iff (!rst_n) mem_cmd == CMD_READ_MULTI);
    c_burst_stop: cover property (@(posedge clock) disable iff (!rst_n) burst_stop);
    c_soft_reset: cover property (@(posedge clock) disable iff (!rst_n) soft_reset);

endmodule : cacheline_latency_regs

// ==== verilog/cfg_pkg.sv ====
// Shared constants for the cache line / latency configuration register block
//
// Overview of operation
// - Self-test byte reads zero, writes ignored.
// - Header byte reports layout and function count.
// - Limit applies only after grant withdrawn, multi-phase.
// - Hardware reset clears latency; soft reset keeps.
// - Cache line size counts 32-bit words.
// - Cache line size selects master memory command.
// - Slave prefetch size follows cache line size.
// - Unsupported cache line writes store zero.
// - Accept 0h, 4h, 8h; others below 10h unsupported.
// - Accept 10h and 20h; rest unsupported.
package cfg_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register word indices on the Avalon bus
    localparam logic [1:0] ADDR_CFG_WORD = 2'h0;
    localparam logic [1:0] ADDR_CTRL     = 2'h1;
    localparam logic [1:0] ADDR_STATUS   = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions in bist_header_latency_cacheline
    localparam int BIST_LSB = 24;
    localparam int HDR_LSB  = 16;
    localparam int LAT_LSB  = 8;
    localparam int CLS_LSB  = 0;

    // Control register bits
    localparam int CTRL_SOFT_RESET_BIT = 0;
    localparam int CTRL_MWI_EN_BIT     = 1;

    // Status register field positions
    localparam int STAT_COUNT_LSB   = 0;
    localparam int STAT_EXPIRED_BIT = 8;
    localparam int STAT_STOP_BIT    = 9;
    localparam int STAT_CMD_LSB     = 12;

    ////////////////////////////////////////////////////////////////////////////
    // Reset and hardwired values
    localparam logic [7:0]  BIST_VALUE         = 8'h00;
    localparam logic [7:0]  HDR_LAYOUT_DEFAULT = 8'h00;
    localparam logic [7:0]  LAT_RESET          = 8'h00;
    localparam logic [7:0]  CLS_RESET          = 8'h00;
    localparam logic        MWI_EN_RESET       = 1'b0;
    localparam logic [7:0]  PREFETCH_MIN       = 8'h01;
    localparam logic [31:0] READ_ZERO          = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // Supported cache line sizes, in 32-bit words
    localparam logic [7:0] CLS_DISABLED = 8'h00;
    localparam logic [7:0] CLS_16_BYTES = 8'h04;
    localparam logic [7:0] CLS_32_BYTES = 8'h08;
    localparam logic [7:0] CLS_64_BYTES = 8'h10;
    localparam logic [7:0] CLS_128_BYTES = 8'h20;

    ////////////////////////////////////////////////////////////////////////////
    // Memory command encodings on the bus
    localparam logic [3:0] CMD_MEM_READ   = 4'h6;
    localparam logic [3:0] CMD_MEM_WRITE  = 4'h7;
    localparam logic [3:0] CMD_READ_MULTI = 4'hC;
    localparam logic [3:0] CMD_READ_LINE  = 4'hE;
    localparam logic [3:0] CMD_WRITE_INV  = 4'hF;

endpackage : cfg_pkg

// ==== verilog/latency_counter.sv ====
// Master latency counter: loads at frame start, ends multi-phase bursts on expiry once grant is withdrawn
`timescale 1ns/10ps
module latency_counter
    import cfg_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             frame_start,
    input  wire logic             frame_active,
    input  wire logic             bus_grant_input,
    input  wire logic             multi_phase,
    input  wire logic [WIDTH-1:0] limit,
    output logic      [WIDTH-1:0] count_q,
    output logic                  expired_q,
    output logic                  stop_q
);

    logic [WIDTH-1:0] count_d;
    logic             expired_d;
    logic             stop_d;

    always_comb begin
        count_d = count_q;
        if (frame_start) begin
            count_d = limit;
        end else if (frame_active && count_q != '0) begin
            count_d = count_q - 1'b1;
        end
        expired_d = (frame_start || frame_active) && (count_d == '0);
        // Grant still held means the limit is not enforced
        stop_d = expired_d && multi_phase && !bus_grant_input;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_q   <= '0;
            expired_q <= 1'b0;
            stop_q    <= 1'b0;
        end else begin
            count_q   <= count_d;
            expired_q <= expired_d;
            stop_q    <= stop_d;
        end
    end

endmodule : latency_counter
